//--- pkg/scr_pkg.sv
// Contract
// - pump, vco and coarse cal registers reset on sleep mode wake
// - vco current field 4:0 resets 01010
// - coarse cap field 5:0 resets 100000
// - written triple drives synthesizer tuning outputs
// - cal control field 6:0 resets 0001101
// - vco selection stage only when bit set
// - skip pump stage when enable is zero
package scr_pkg;
    // register word indices; the byte address on the bus is four times the index
    localparam logic [15:0] ADDR_PUMP_CAL = 16'hDF1C;
    localparam logic [15:0] ADDR_VCO_CUR = 16'hDF1D;
    localparam logic [15:0] ADDR_COARSE = 16'hDF1E;
    localparam logic [15:0] ADDR_CAL_CTRL = 16'hDF1F;
    localparam logic [15:0] ADDR_TEST_CFG_2 = 16'hDF23;
    localparam logic [15:0] ADDR_TEST_CFG_1 = 16'hDF24;
    localparam logic [15:0] ADDR_TEST_CFG_0 = 16'hDF25;
    localparam logic [7:0] RST_PUMP_CAL = 8'hA9;
    localparam logic [7:0] RST_VCO_CUR = 8'h0A;
    localparam logic [7:0] RST_COARSE = 8'h20;
    localparam logic [7:0] RST_CAL_CTRL = 8'h0D;
    localparam logic [7:0] RST_TEST_CFG_2 = 8'h88;
    localparam logic [7:0] RST_TEST_CFG_1 = 8'h11;
    localparam logic [7:0] RST_TEST_CFG_0 = 8'h0B;
    localparam logic [7:0] MASK_PUMP_CAL = 8'hFF;
    localparam logic [7:0] MASK_VCO_CUR = 8'h3F;
    localparam logic [7:0] MASK_COARSE = 8'h3F;
    localparam logic [7:0] MASK_CAL_CTRL = 8'h7F;
    localparam int PUMP_EN_LSB = 4;
    localparam int VCO_SEL_EN_BIT = 1;
    localparam int VCO_HIGH_BIT = 5;
    typedef struct packed {
        logic [7:0] pump_cal;
        logic [7:0] vco_cur;
        logic [7:0] coarse;
    } scr_triple_t;
endpackage : scr_pkg

//--- src/scr_regs.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module scr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_from_sleep,
    input wire logic cal_result_valid,
    input wire scr_pkg::scr_triple_t cal_result,
    output scr_pkg::scr_triple_t tune_settings,
    output logic [6:0] synth_cal_control,
    output logic vco_high_select,
    output logic pump_cal_stage_en,
    output logic vco_choice_cal_stage_en,
    output logic [7:0] test_cfg_0,
    output logic [7:0] test_cfg_1,
    output logic [7:0] test_cfg_2
);
    // a register is addressed by its word index; the two byte-lane bits must be zero
    function automatic logic addr_match(input logic [17:0] addr, input logic [15:0] index);
        addr_match = (addr[17:2] == index) && (addr[1:0] == 2'b00);
    endfunction : addr_match

    // calibration triple, reloaded with its reset values again on every wake from the deep sleep modes
    logic [7:0] pump_reg;
    logic [7:0] vco_reg;
    logic [7:0] coarse_reg;

    // settings that only software changes
    logic [7:0] ctrl_reg;
    logic [7:0] t0_reg;
    logic [7:0] t1_reg;
    logic [7:0] t2_reg;

    // access-phase write strobe and one select per register
    logic wr;
    logic wr_pump;
    logic wr_vco;
    logic wr_coarse;
    logic wr_ctrl;
    logic wr_t0;
    logic wr_t1;
    logic wr_t2;

    // read word for the address on the bus, captured into prdata at setup
    logic [7:0] rd_next;

    // no wait states and no error response: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // only byte lane zero carries register data
    assign wr = psel && penable && pwrite && pstrb[0];
    assign wr_pump = wr && addr_match(paddr, scr_pkg::ADDR_PUMP_CAL);
    assign wr_vco = wr && addr_match(paddr, scr_pkg::ADDR_VCO_CUR);
    assign wr_coarse = wr && addr_match(paddr, scr_pkg::ADDR_COARSE);
    assign wr_ctrl = wr && addr_match(paddr, scr_pkg::ADDR_CAL_CTRL);
    assign wr_t0 = wr && addr_match(paddr, scr_pkg::ADDR_TEST_CFG_0);
    assign wr_t1 = wr && addr_match(paddr, scr_pkg::ADDR_TEST_CFG_1);
    assign wr_t2 = wr && addr_match(paddr, scr_pkg::ADDR_TEST_CFG_2);

    // pump calibration: wake first, then a software write, then a calibration result
    // so a restored hop value is never overwritten by a stale result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_reg <= scr_pkg::RST_PUMP_CAL;
        end else if (wake_from_sleep) begin
            pump_reg <= scr_pkg::RST_PUMP_CAL;
        end else if (wr_pump) begin
            pump_reg <= pwdata[7:0];
        end else if (cal_result_valid) begin
            pump_reg <= cal_result.pump_cal;
        end
    end

    // vco current: bit 5 is the vco choice, which a calibration result never moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_reg <= scr_pkg::RST_VCO_CUR;
        end else if (wake_from_sleep) begin
            vco_reg <= scr_pkg::RST_VCO_CUR;
        end else if (wr_vco) begin
            vco_reg <= pwdata[7:0] & scr_pkg::MASK_VCO_CUR;
        end else if (cal_result_valid) begin
            vco_reg <= {2'b00, vco_reg[scr_pkg::VCO_HIGH_BIT], cal_result.vco_cur[4:0]};
        end
    end

    // coarse capacitor array setting, six bits wide
    // upper bits are masked on every load path, so they can never read back as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_reg <= scr_pkg::RST_COARSE;
        end else if (wake_from_sleep) begin
            coarse_reg <= scr_pkg::RST_COARSE;
        end else if (wr_coarse) begin
            coarse_reg <= pwdata[7:0] & scr_pkg::MASK_COARSE;
        end else if (cal_result_valid) begin
            coarse_reg <= cal_result.coarse & scr_pkg::MASK_COARSE;
        end
    end

    // calibration control is only a stored setting; it survives a wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= scr_pkg::RST_CAL_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0] & scr_pkg::MASK_CAL_CTRL;
        end
    end

    // test setting zero carries the vco selection stage enable in bit 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_reg <= scr_pkg::RST_TEST_CFG_0;
        end else if (wr_t0) begin
            t0_reg <= pwdata[7:0];
        end
    end

    // test setting one: the value for transmit or receive is software's business
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_reg <= scr_pkg::RST_TEST_CFG_1;
        end else if (wr_t1) begin
            t1_reg <= pwdata[7:0];
        end
    end

    // test setting two, all eight bits writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t2_reg <= scr_pkg::RST_TEST_CFG_2;
        end else if (wr_t2) begin
            t2_reg <= pwdata[7:0];
        end
    end

    // read decode on the word index; unmapped words read zero without an error
    always_comb begin
        rd_next = 8'h00;
        case (paddr[17:2])
            scr_pkg::ADDR_PUMP_CAL: begin
                rd_next = pump_reg;
            end
            scr_pkg::ADDR_VCO_CUR: begin
                rd_next = vco_reg;
            end
            scr_pkg::ADDR_COARSE: begin
                rd_next = coarse_reg;
            end
            scr_pkg::ADDR_CAL_CTRL: begin
                rd_next = ctrl_reg;
            end
            scr_pkg::ADDR_TEST_CFG_0: begin
                rd_next = t0_reg;
            end
            scr_pkg::ADDR_TEST_CFG_1: begin
                rd_next = t1_reg;
            end
            scr_pkg::ADDR_TEST_CFG_2: begin
                rd_next = t2_reg;
            end
            default: begin
                rd_next = 8'h00;
            end
        endcase
        // unaligned byte addresses do not alias onto a register
        if (paddr[1:0] != 2'b00) begin
            rd_next = 8'h00;
        end
    end

    // read data is registered at the setup edge and stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_next};
        end
    end

    // the synthesizer tunes from whatever the triple holds, result or written value
    assign tune_settings.pump_cal = pump_reg;
    assign tune_settings.vco_cur = {3'b000, vco_reg[4:0]};
    assign tune_settings.coarse = coarse_reg;
    assign vco_high_select = vco_reg[scr_pkg::VCO_HIGH_BIT];
    assign synth_cal_control = ctrl_reg[6:0];

    // stage enables for the calibration sequencer
    assign pump_cal_stage_en = |pump_reg[scr_pkg::PUMP_EN_LSB +: 2];
    assign vco_choice_cal_stage_en = t0_reg[scr_pkg::VCO_SEL_EN_BIT];

    // test settings go out unchanged
    assign test_cfg_0 = t0_reg;
    assign test_cfg_1 = t1_reg;
    assign test_cfg_2 = t2_reg;
endmodule : scr_regs

//--- verif/scr_checker.sv
`timescale 1ns/10ps
module scr_checker (
    input wire logic pclk, presetn, psel, penable, pwrite, wake_from_sleep,
    input wire logic pump_cal_stage_en, vco_choice_cal_stage_en,
    input wire logic [17:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [6:0] synth_cal_control,
    input wire logic [7:0] test_cfg_0,
    input wire scr_pkg::scr_triple_t tune_settings
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // wake outranks a software write, so such writes are not expected to land
    wire wr = psel && penable && pwrite && pstrb[0] && !wake_from_sleep;
    sequence boot_s; $rose(presetn); endsequence
    wake_rst_a: assert property (wake_from_sleep |=> tune_settings == 24'hA90A20) else $error("wake reset");
    vco_rst_a: assert property (boot_s |-> tune_settings.vco_cur == 8'h0A) else $error("vco reset");
    cap_rst_a: assert property (boot_s |-> tune_settings.coarse == 8'h20) else $error("cap reset");
    cap_write_a: assert property (wr && paddr == {16'hDF1E, 2'b00} |=> tune_settings.coarse == ($past(pwdata) & 32'h3F))
        else $error("cap write");
    ctrl_rst_a: assert property (boot_s |-> synth_cal_control == 7'h0D) else $error("ctrl reset");
    sel_stage_a: assert property (vco_choice_cal_stage_en == test_cfg_0[1]) else $error("sel stage");
    pump_stage_a: assert property (pump_cal_stage_en == |tune_settings.pump_cal[5:4]) else $error("pump stage");
    upper_zero_a: assert property (prdata[31:8] == 24'h0 && tune_settings.coarse[7:6] == 2'h0) else $error("upper bits");
endmodule : scr_checker

//--- verif/synth_calibration_regs_tb.sv
`timescale 1ns/10ps
module synth_calibration_regs_tb;
    logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0, pready, pslverr, wake_from_sleep=0;
    logic cal_result_valid=0, vco_high_select, pump_cal_stage_en, vco_choice_cal_stage_en;
    logic [17:0] paddr='0;
    logic [31:0] pwdata='0, prdata;
    logic [3:0] pstrb=4'hF;
    logic [6:0] synth_cal_control;
    logic [7:0] test_cfg_0, test_cfg_1, test_cfg_2, q;
    scr_pkg::scr_triple_t cal_result='0, tune_settings;
    int num_errors=0, samples_checked=0;
    logic [15:0] ad[8]='{16'hDF1C,16'hDF1D,16'hDF1E,16'hDF1F,16'hDF23,16'hDF24,16'hDF25,16'hDF20};
    logic [7:0] ex[8]='{8'hA9,8'h0A,8'h20,8'h0D,8'h88,8'h11,8'h0B,8'h00};
    logic [7:0] mk[4]='{8'hFF,8'h3F,8'h3F,8'h7F};
    scr_regs i_dut (.*);
    initial forever #10 pclk = ~pclk;
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // one idle cycle after each transfer keeps psel from being driven twice in a step
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= {a, 2'b00}; pwdata <= {24'h0, d};
        @(posedge pclk) penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin num_errors++; print_verdict(); end
        r = prdata[7:0];
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i=0; i<8; i++) begin bus(0, ad[i], 8'h00, q); chk("reset", q, ex[i]); end
        chk("bus answer", {pready, pslverr}, 2'b10);
        $display("reset test done");
        for (int i=1; i<4; i++) begin bus(1, ad[i], 8'hFF, q); bus(0, ad[i], 8'h00, q); chk("mask", q, mk[i]); end
        chk("tune", tune_settings, 24'hA91F3F);
        chk("vco high", vco_high_select, 1'b1);
        chk("ctrl out", synth_cal_control, 7'h7F);
        chk("pump on", pump_cal_stage_en, 1'b1);
        bus(1, ad[0], 8'h8F, q); chk("pump off", pump_cal_stage_en, 1'b0);
        bus(1, ad[6], 8'h09, q); chk("vco sel", vco_choice_cal_stage_en, 1'b0);
        chk("test zero", test_cfg_0, 8'h09);
        bus(1, ad[5], 8'h35, q); chk("test one rx", test_cfg_1, 8'h35);
        bus(1, ad[5], 8'h31, q); chk("test one", test_cfg_1, 8'h31);
        bus(1, ad[4], 8'h81, q); chk("test two", test_cfg_2, 8'h81);
        $display("write test done");
        cal_result <= 24'h000511; cal_result_valid <= 1'b1;
        @(posedge pclk) cal_result_valid <= 1'b0;
        bus(0, ad[1], 8'h00, q); chk("saved vco", q, 8'h25);
        @(posedge pclk) wake_from_sleep <= 1'b1;
        chk("cal load", tune_settings, 24'h000511);
        @(posedge pclk) wake_from_sleep <= 1'b0;
        @(posedge pclk) chk("wake", tune_settings, 24'hA90A20);
        chk("wake vco high", vco_high_select, 1'b0);
        bus(0, ad[3], 8'h00, q); chk("ctrl kept", q, 8'h7F);
        bus(1, ad[0], 8'h00, q);
        bus(1, ad[1], 8'h25, q);
        bus(1, ad[2], 8'h11, q);
        chk("restored", tune_settings, 24'h000511);
        $display("wake test done");
        print_verdict();
    end
endmodule : synth_calibration_regs_tb
bind scr_regs scr_checker i_chk (.*);
